// File: logic/dos_servo_ctrl.sv
// output offset servo control: triggers, series, periodic timer, bus slave
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module dos_servo_ctrl #(
    parameter int TICK_CYCLES = dos_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // completion pulses from the start-up and write-mode servo logic
    input wire logic [3:0] startup_done_pulse,
    input wire logic [3:0] write_done_pulse,
    // analogue measurement handshake
    output logic [3:0] meas_req,
    input wire logic [3:0] meas_done,
    input wire logic [3:0] meas_high,
    // correction values and gating
    output logic [31:0] offset_correction_value,
    output logic [3:0] servo_channel_enable,
    // interrupt
    output logic irq
);

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);

    // ************************************************************
    // state
    // ************************************************************
    logic dp_write_reg, dp_write_next;
    logic dp_read_reg, dp_read_next;
    logic dp_hit_reg, dp_hit_next;
    logic [7:0] dp_idx_reg, dp_idx_next;
    logic hreadyout_reg, hreadyout_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [3:0] enable_reg, enable_next;
    logic [3:0] line_period_reg, line_period_next;
    logic [3:0] hp_period_reg, hp_period_next;
    logic [6:0] line_count_reg, line_count_next;
    logic [6:0] hp_count_reg, hp_count_next;
    logic [7:0] done_flags_reg, done_flags_next;
    logic [3:0] irq_status_reg, irq_status_next;
    logic [3:0] irq_mask_reg, irq_mask_next;
    logic irq_reg, irq_next;
    logic [PW-1:0] presc_reg, presc_next;
    logic [15:0] pair_cnt_reg [2];
    logic [15:0] pair_cnt_next [2];
    logic [3:0] done_s1_reg, done_s2_reg;
    logic [3:0] high_s1_reg, high_s2_reg;
    dos_pkg::dos_chan_state_t state_reg [4];
    dos_pkg::dos_chan_state_t state_next [4];
    logic [7:0] ops_reg [4];
    logic [7:0] ops_next [4];
    logic [7:0] corr_reg [4];
    logic [7:0] corr_next [4];
    logic [3:0] single_busy_reg, single_busy_next;
    logic [3:0] series_busy_reg, series_busy_next;
    logic [3:0] meas_req_reg, meas_req_next;

    logic take, wr_en, rd_en, tick;
    logic [1:0] fire;
    logic [3:0] single_go, series_go, periodic_go, chan_event;
    logic [3:0] period_of [2];
    logic [15:0] limit [2];

    // ************************************************************
    // bus slave: writes zero wait, reads one wait state
    // ************************************************************
    // the read wait state lets a write in the previous data phase land
    // before the read value is sampled
    always_comb
    begin
        take = hsel && htrans[1] && hready;
        dp_write_next = take && hwrite;
        dp_read_next = take && !hwrite;
        dp_idx_next = take ? haddr[dos_pkg::IDX_MSB:dos_pkg::IDX_LSB] : dp_idx_reg;
        dp_hit_next = take ? (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0) : dp_hit_reg;
        hreadyout_next = !(take && !hwrite);
        wr_en = dp_write_reg && dp_hit_reg;
        rd_en = dp_read_reg && dp_hit_reg;
        hrdata_next = hrdata_reg;
        if (dp_read_reg)
        begin
            hrdata_next = 32'h0;
            if (dp_hit_reg)
            begin
                unique case (dp_idx_reg)
                    dos_pkg::IDX_ENABLE: hrdata_next = {28'h0, enable_reg};
                    dos_pkg::IDX_TRIGGER:
                        hrdata_next = {16'h0, single_busy_reg, series_busy_reg, 8'h0};
                    dos_pkg::IDX_PERIODS:
                        hrdata_next = {20'h0, line_period_reg, 4'h0, hp_period_reg};
                    dos_pkg::IDX_STATUS: hrdata_next = {24'h0, done_flags_reg};
                    dos_pkg::IDX_LINE_COUNT: hrdata_next = {25'h0, line_count_reg};
                    dos_pkg::IDX_HP_COUNT: hrdata_next = {25'h0, hp_count_reg};
                    dos_pkg::IDX_CORRECTION:
                        hrdata_next = {corr_reg[3], corr_reg[2], corr_reg[1], corr_reg[0]};
                    dos_pkg::IDX_IRQ_STATUS: hrdata_next = {28'h0, irq_status_reg};
                    dos_pkg::IDX_IRQ_MASK: hrdata_next = {28'h0, irq_mask_reg};
                    default: hrdata_next = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write_reg <= 1'b0;
            dp_read_reg <= 1'b0;
            dp_hit_reg <= 1'b0;
            dp_idx_reg <= 8'h0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h0;
        end
        else
        begin
            dp_write_reg <= dp_write_next;
            dp_read_reg <= dp_read_next;
            dp_hit_reg <= dp_hit_next;
            dp_idx_reg <= dp_idx_next;
            hreadyout_reg <= hreadyout_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // ************************************************************
    // configuration, status and interrupt registers
    // ************************************************************
    always_comb
    begin
        enable_next = enable_reg;
        line_period_next = line_period_reg;
        hp_period_next = hp_period_reg;
        line_count_next = line_count_reg;
        hp_count_next = hp_count_reg;
        irq_mask_next = irq_mask_reg;
        if (wr_en)
        begin
            unique case (dp_idx_reg)
                dos_pkg::IDX_ENABLE: enable_next = hwdata[3:0];
                dos_pkg::IDX_PERIODS:
                begin
                    line_period_next = hwdata[dos_pkg::LINE_PERIOD_LSB +: 4];
                    hp_period_next = hwdata[dos_pkg::HP_PERIOD_LSB +: 4];
                end
                dos_pkg::IDX_LINE_COUNT: line_count_next = hwdata[6:0];
                dos_pkg::IDX_HP_COUNT: hp_count_next = hwdata[6:0];
                dos_pkg::IDX_IRQ_MASK: irq_mask_next = hwdata[3:0];
                default: enable_next = enable_reg;
            endcase
        end
        // sticky start-up and write-mode done flags
        // a flag is dropped when its channel is disabled; a new pulse wins
        done_flags_next = (done_flags_reg & {enable_reg, enable_reg})
            | {write_done_pulse, startup_done_pulse};
        // set wins over the clear-on-read
        irq_status_next = chan_event
            | (irq_status_reg & ~{4{rd_en && dp_idx_reg == dos_pkg::IDX_IRQ_STATUS}});
        irq_next = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable_reg <= 4'h0;
            line_period_reg <= dos_pkg::PERIOD_RST;
            hp_period_reg <= dos_pkg::PERIOD_RST;
            line_count_reg <= dos_pkg::COUNT_RST;
            hp_count_reg <= dos_pkg::COUNT_RST;
            done_flags_reg <= 8'h0;
            irq_status_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            irq_reg <= 1'b0;
        end
        else
        begin
            enable_reg <= enable_next;
            line_period_reg <= line_period_next;
            hp_period_reg <= hp_period_next;
            line_count_reg <= line_count_next;
            hp_count_reg <= hp_count_next;
            done_flags_reg <= done_flags_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
        end
    end

    // ************************************************************
    // periodic update timer
    // ************************************************************
    always_comb
    begin
        tick = (presc_reg == PRESC_LAST);
        presc_next = (tick || (wr_en && dp_idx_reg == dos_pkg::IDX_PERIODS))
            ? '0 : PW'(presc_reg + 1'b1);
        period_of[dos_pkg::HP_PAIR] = hp_period_reg;
        period_of[dos_pkg::LINE_PAIR] = line_period_reg;
        for (int p = 0; p < 2; p++)
        begin
            // interval of two to the code ticks
            limit[p] = 16'((17'h1 << period_of[p]) - 17'h1);
            fire[p] = tick && period_of[p] != dos_pkg::PERIOD_OFF && pair_cnt_reg[p] == limit[p];
            if (period_of[p] == dos_pkg::PERIOD_OFF
                || (wr_en && dp_idx_reg == dos_pkg::IDX_PERIODS) || fire[p])
                pair_cnt_next[p] = 16'h0;
            else if (tick)
                pair_cnt_next[p] = 16'(pair_cnt_reg[p] + 16'h1);
            else
                pair_cnt_next[p] = pair_cnt_reg[p];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            presc_reg <= '0;
            pair_cnt_reg[0] <= 16'h0;
            pair_cnt_reg[1] <= 16'h0;
        end
        else
        begin
            presc_reg <= presc_next;
            pair_cnt_reg[0] <= pair_cnt_next[0];
            pair_cnt_reg[1] <= pair_cnt_next[1];
        end
    end

    // ************************************************************
    // per-channel measure-and-correct engines
    // ************************************************************
    // a trigger on a busy channel is dropped rather than queued
    always_comb
    begin
        single_busy_next = single_busy_reg;
        series_busy_next = series_busy_reg;
        for (int i = 0; i < dos_pkg::NUM_CHAN; i++)
        begin
            state_next[i] = state_reg[i];
            ops_next[i] = ops_reg[i];
            corr_next[i] = corr_reg[i];
            meas_req_next[i] = meas_req_reg[i];
            chan_event[i] = 1'b0;
            // zero bits and disabled channels ignored
            single_go[i] = wr_en && dp_idx_reg == dos_pkg::IDX_TRIGGER
                && hwdata[dos_pkg::SINGLE_LSB + i] && enable_reg[i]
                && state_reg[i] == dos_pkg::CH_IDLE;
            series_go[i] = wr_en && dp_idx_reg == dos_pkg::IDX_TRIGGER
                && hwdata[dos_pkg::SERIES_LSB + i] && enable_reg[i]
                && state_reg[i] == dos_pkg::CH_IDLE && !single_go[i];
            periodic_go[i] = fire[i / 2] && enable_reg[i]
                && state_reg[i] == dos_pkg::CH_IDLE && !single_go[i] && !series_go[i];
            unique case (state_reg[i])
                dos_pkg::CH_IDLE:
                begin
                    if (single_go[i] || periodic_go[i])
                    begin
                        ops_next[i] = 8'h1;
                        single_busy_next[i] = single_go[i];
                        state_next[i] = dos_pkg::CH_MEAS;
                        meas_req_next[i] = 1'b1;
                    end
                    else if (series_go[i])
                    begin
                        ops_next[i] = (i >= 2) ? 8'(line_count_reg) + 8'h1
                            : 8'(hp_count_reg) + 8'h1;
                        series_busy_next[i] = 1'b1;
                        state_next[i] = dos_pkg::CH_MEAS;
                        meas_req_next[i] = 1'b1;
                    end
                end
                dos_pkg::CH_MEAS:
                begin
                    if (done_s2_reg[i])
                    begin
                        if (high_s2_reg[i] && corr_reg[i] != dos_pkg::CORR_MIN)
                            corr_next[i] = 8'(corr_reg[i] - 8'h1);
                        else if (!high_s2_reg[i] && corr_reg[i] != dos_pkg::CORR_MAX)
                            corr_next[i] = 8'(corr_reg[i] + 8'h1);
                        ops_next[i] = 8'(ops_reg[i] - 8'h1);
                        meas_req_next[i] = 1'b0;
                        state_next[i] = dos_pkg::CH_RELEASE;
                    end
                end
                dos_pkg::CH_RELEASE:
                begin
                    if (!done_s2_reg[i])
                    begin
                        // a disabled channel stops after the step in flight
                        if (ops_reg[i] != 8'h0 && enable_reg[i])
                        begin
                            meas_req_next[i] = 1'b1;
                            state_next[i] = dos_pkg::CH_MEAS;
                        end
                        else
                        begin
                            single_busy_next[i] = 1'b0;
                            series_busy_next[i] = 1'b0;
                            ops_next[i] = 8'h0;
                            chan_event[i] = 1'b1;
                            state_next[i] = dos_pkg::CH_IDLE;
                        end
                    end
                end
                default: state_next[i] = dos_pkg::CH_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < dos_pkg::NUM_CHAN; i++)
            begin
                state_reg[i] <= dos_pkg::CH_IDLE;
                ops_reg[i] <= 8'h0;
                corr_reg[i] <= 8'h0;
            end
            single_busy_reg <= 4'h0;
            series_busy_reg <= 4'h0;
            meas_req_reg <= 4'h0;
            done_s1_reg <= 4'h0;
            done_s2_reg <= 4'h0;
            high_s1_reg <= 4'h0;
            high_s2_reg <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < dos_pkg::NUM_CHAN; i++)
            begin
                state_reg[i] <= state_next[i];
                ops_reg[i] <= ops_next[i];
                corr_reg[i] <= corr_next[i];
            end
            single_busy_reg <= single_busy_next;
            series_busy_reg <= series_busy_next;
            meas_req_reg <= meas_req_next;
            // analogue handshake inputs are asynchronous
            done_s1_reg <= meas_done;
            done_s2_reg <= done_s1_reg;
            high_s1_reg <= meas_high;
            high_s2_reg <= high_s1_reg;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign meas_req = meas_req_reg;
    assign offset_correction_value = {corr_reg[3], corr_reg[2], corr_reg[1], corr_reg[0]};
    assign servo_channel_enable = enable_reg;
    assign irq = irq_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_single_start;
        single_go[0] ##1 (ops_reg[0] == 8'h1 && meas_req_reg[0] && single_busy_reg[0]);
    endsequence

    single_start_a: assert property (single_go[0] |-> s_single_start)
        else $error("single trigger did not start one operation");
    step_size_a: assert property ($changed(corr_reg[1]) |->
        (8'(corr_reg[1] - $past(corr_reg[1])) == 8'h01
        || 8'(corr_reg[1] - $past(corr_reg[1])) == 8'hff))
        else $error("correction moved by more than one lsb");
    disabled_idle_a: assert property ((state_reg[2] == dos_pkg::CH_IDLE
        && !enable_reg[2]) |=> state_reg[2] == dos_pkg::CH_IDLE)
        else $error("disabled channel left idle");
    series_len_a: assert property (series_go[2] |=>
        ops_reg[2] == 8'($past(line_count_reg)) + 8'h1 && series_busy_reg[2])
        else $error("series length is not count plus one");
    series_hp_a: assert property (series_go[0] |=>
        ops_reg[0] == 8'($past(hp_count_reg)) + 8'h1)
        else $error("headphone series used the wrong count");
    busy_hold_a: assert property ((single_busy_reg[0]
        && state_reg[0] != dos_pkg::CH_RELEASE) |=> single_busy_reg[0])
        else $error("single busy dropped before completion");
    series_end_a: assert property ($fell(series_busy_reg[2]) |->
        $past(state_reg[2]) == dos_pkg::CH_RELEASE && chan_event[2] == 1'b0
        && irq_status_reg[2])
        else $error("series busy ended without completion event");
    period_off_a: assert property ((hp_period_reg == dos_pkg::PERIOD_OFF
        && state_reg[0] == dos_pkg::CH_IDLE && !single_go[0] && !series_go[0])
        |=> state_reg[0] == dos_pkg::CH_IDLE)
        else $error("periodic update while period is off");
    period_due_a: assert property (fire[0] |->
        pair_cnt_reg[0] == 16'((17'h1 << hp_period_reg) - 17'h1) && tick)
        else $error("periodic update at wrong interval");
    zero_write_a: assert property ((wr_en && dp_idx_reg == dos_pkg::IDX_TRIGGER
        && hwdata[15:8] == 8'h0 && !fire[0] && !fire[1]) |-> !(|(single_go | series_go)))
        else $error("zero trigger write started an operation");
    timer_restart_a: assert property ((wr_en && dp_idx_reg == dos_pkg::IDX_PERIODS)
        |=> presc_reg == '0 && pair_cnt_reg[0] == 16'h0 && pair_cnt_reg[1] == 16'h0)
        else $error("timer not restarted by period write");
    done_flag_a: assert property (write_done_pulse[1] |=> done_flags_reg[5])
        else $error("write-mode done flag not set");
    irq_level_a: assert property (irq_reg == |(irq_status_reg & irq_mask_reg))
        else $error("interrupt level does not follow masked status");

endmodule

// File: include/dos_pkg.sv
// constants and types shared by the output offset servo control block
package dos_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_ENABLE = 8'h40;
    localparam logic [7:0] IDX_TRIGGER = 8'h44;
    localparam logic [7:0] IDX_PERIODS = 8'h45;
    localparam logic [7:0] IDX_STATUS = 8'h46;
    localparam logic [7:0] IDX_LINE_COUNT = 8'h47;
    localparam logic [7:0] IDX_HP_COUNT = 8'h48;
    localparam logic [7:0] IDX_CORRECTION = 8'h49;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h4a;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h4b;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SINGLE_LSB = 12;
    localparam int SERIES_LSB = 8;
    localparam int WRITE_DONE_LSB = 4;
    localparam int STARTUP_DONE_LSB = 0;
    localparam int LINE_PERIOD_LSB = 8;
    localparam int HP_PERIOD_LSB = 0;
    localparam int NUM_CHAN = 4;
    localparam int LINE_PAIR = 1;
    localparam int HP_PAIR = 0;

    // ************************************************************
    // reset values and limits
    // ************************************************************
    localparam logic [6:0] COUNT_RST = 7'h2a;
    localparam logic [3:0] PERIOD_RST = 4'ha;
    localparam logic [3:0] PERIOD_OFF = 4'h0;
    localparam logic [7:0] CORR_MAX = 8'h7f;
    localparam logic [7:0] CORR_MIN = 8'h80;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_US = 256000;
    localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {CH_IDLE, CH_MEAS, CH_RELEASE} dos_chan_state_t;

endpackage

// File: verification/output_dc_offset_servo_control_test.sv
// self-checking bench for the output offset servo control block
`timescale 1ns/1ps
module output_dc_offset_servo_control_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd = 0, hreadyout, hresp, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, corr;
    logic [1:0] htrans = 0;
    logic [3:0] sp = 0, wp = 0, mreq, mdone = 0, mhigh = 0, en, req_d = 0;
    logic [11:0] dly = 0;
    int ops[4];
    int quiet = 0, errors = 0, check_count = 0, v, b;
    logic [31:0] exp_q[$];
    always #5 hclk = ~hclk;
    dos_servo_ctrl #(.TICK_CYCLES(20)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .startup_done_pulse(sp), .write_done_pulse(wp), .meas_req(mreq), .meas_done(mdone),
        .meas_high(mhigh), .offset_correction_value(corr), .servo_channel_enable(en), .irq(irq));
    // ************************************************************
    // analogue side: done follows request four cycles late, both ways
    // ************************************************************
    always @(posedge hclk)
    begin
        dly <= {dly[7:0], mreq};
        mdone <= dly[11:8];
        req_d <= mreq;
        quiet <= (mreq != 4'h0) ? 0 : quiet + 1;
        for (int i = 0; i < 4; i++)
            if (mreq[i] && !req_d[i]) ops[i] <= ops[i] + 1;
    end
    task chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want)
        begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    always @(posedge hclk)
        if (rd && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front());
    // read: d is the expected data, taken when the data phase ends
    task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd <= !w;
        if (!w) exp_q.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd <= 1'b0;
    endtask
    // the first cycles are skipped: a request rises only after the trigger edge
    task wait_idle;
        repeat (3) @(posedge hclk);
        for (int k = 0; k < 3000 && quiet < 20; k++) @(posedge hclk);
        if (quiet < 20) errors++;
    endtask
    task give_verdict;
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        give_verdict();
    end
    initial
    begin
        v = $urandom(32'hfb63);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, dos_pkg::IDX_PERIODS, 32'h0a0a);
        bus(0, dos_pkg::IDX_LINE_COUNT, 32'h2a);
        bus(0, dos_pkg::IDX_HP_COUNT, 32'h2a);
        bus(0, dos_pkg::IDX_STATUS, 32'h0);
        bus(0, dos_pkg::IDX_TRIGGER, 32'h0);
        bus(0, 8'h50, 32'h0);
        bus(1, dos_pkg::IDX_PERIODS, 32'h0);
        bus(1, dos_pkg::IDX_ENABLE, 32'h7);
        bus(1, dos_pkg::IDX_IRQ_MASK, 32'hf);
        bus(1, dos_pkg::IDX_TRIGGER, 32'h0);
        bus(1, dos_pkg::IDX_TRIGGER, 32'h1000);
        bus(0, dos_pkg::IDX_TRIGGER, 32'h1000);
        wait_idle();
        chk(ops[0], 1);
        chk({31'h0, irq}, 1);
        bus(0, dos_pkg::IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 0);
        bus(0, dos_pkg::IDX_CORRECTION, 32'h1);
        v = $urandom % 4;
        mhigh <= 4'h4;
        bus(1, dos_pkg::IDX_LINE_COUNT, v);
        bus(1, dos_pkg::IDX_TRIGGER, 32'h0c00);
        bus(0, dos_pkg::IDX_TRIGGER, 32'h0400);
        wait_idle();
        chk(ops[2], v + 1);
        chk(ops[3], 0);
        bus(0, dos_pkg::IDX_CORRECTION, {8'h0, 8'(-(v + 1)), 16'h0001});
        chk(corr, {8'h0, 8'(-(v + 1)), 16'h0001});
        chk({28'h0, en}, 32'h7);
        chk({31'h0, hresp}, 0);
        sp <= 4'b0101;
        wp <= 4'b0010;
        @(posedge hclk);
        sp <= 4'h0;
        wp <= 4'h0;
        bus(0, dos_pkg::IDX_STATUS, 32'h25);
        b = ops[0];
        bus(1, dos_pkg::IDX_HP_COUNT, 32'h5);
        bus(1, dos_pkg::IDX_TRIGGER, 32'h0100);
        wait_idle();
        chk(ops[0] - b, 6);
        mhigh <= 4'($urandom);
        b = ops[1];
        bus(1, dos_pkg::IDX_PERIODS, 32'h1);
        repeat (30) @(posedge hclk);
        chk(ops[1] - b, 0);
        repeat (30) @(posedge hclk);
        chk(ops[1] - b, 1);
        repeat (35) @(posedge hclk);
        chk(ops[1] - b, 2);
        give_verdict();
    end
endmodule
